// ===== verilog/eth_irq_stats_mgmt.sv
// Ethernet interrupt enables, single-collision counter, management address.
// Assumes a classic Wishbone master and event flags held outside the slice.
//
// Summary of operation
// - Bit 14 of the enable register gates the transmit bus error interrupt.
// - Bit 13 of the enable register gates the receive bus error interrupt.
// - Bit 9 gates the receive empty-watermark interrupt.
// - Bit 8 gates the receive full-watermark interrupt.
// - Bit 7 gates the receive-complete interrupt.
// - Bit 6 gates the packet-waiting interrupt.
// - Bit 5 gates the receive-activity interrupt.
// - Bit 3 gates the transmit-complete interrupt.
// - Bit 2 gates the transmit-aborted interrupt.
// - Bit 1 gates the no-receive-descriptor interrupt.
// - Bit 0 gates the receive FIFO overrun interrupt.
// - Unused enable bits read zero; all enables reset to zero.
// - Counter bits 15..0 count frames sent on the second attempt.
// - Reading the counter at 0x10 clears it unless byte lanes 0 and 1 are off.
// - Management PHY select in bits 12..8, reset one, drives the cycle.
// - Management register select in bits 4..0, reset zero, drives cycle.
// - Management address accepts 16/32-bit accesses; byte writes ignored.
// - Each register has clear, set, invert aliases at 0x4, 0x8, 0xC.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "eth_slice_regs.svh"
module eth_irq_stats_mgmt #(
	parameter int NEV = `NUM_EVENTS
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Wishbone slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [7:0]                adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	output logic                           err_o,
	// Controller events, levels in compressed enable order
	input  wire logic [NEV-1:0]            event_flags_i,
	input  wire logic                      single_coll_frame_i,
	// Results
	output logic                           irq_o,
	output eth_slice_pkg::mgmt_addr_s      mgmt_addr_o
);
	import eth_slice_pkg::*;

	logic        req;
	logic        hit_ien;
	logic        hit_scol;
	logic        hit_madr;
	logic        hit_any;
	logic        byte_acc;
	logic        wr_ien;
	logic        wr_scol;
	logic        wr_madr;
	logic        rd_clr;
	alias_e      kind;
	logic [31:0] lanes;
	logic [31:0] ien;
	logic [31:0] scol;
	logic [31:0] madr;
	logic [31:0] rdata;
	logic [31:0] scol_next;
	logic        scol_hw;
	logic [NEV-1:0] gated;
	logic        ack_q;
	logic        err_q;
	logic [31:0] dat_q;
	logic        irq_q;
	mgmt_addr_s  madr_q;
	logic [NEV-1:0] en_vec;
	// Enables by name, highest event first.
	logic        tx_sysbus_err_int_en;
	logic        rx_sysbus_err_int_en;
	logic        empty_watermark_int_en;
	logic        full_watermark_int_en;
	logic        rx_complete_int_en;
	logic        packet_waiting_int_en;
	logic        rx_activity_int_en;
	logic        tx_complete_int_en;
	logic        tx_aborted_int_en;
	logic        rx_no_descriptor_int_en;
	logic        rx_fifo_overrun_int_en;

	// A request is answered one cycle after it is seen, then ack drops.
	assign req      = cyc_i & stb_i & ~ack_q & ~err_q;
	assign hit_ien  = {adr_i[7:4], 4'h0} == `IEN_BASE;
	assign hit_scol = {adr_i[7:4], 4'h0} == `SCOL_BASE;
	assign hit_madr = {adr_i[7:4], 4'h0} == `MADR_BASE;
	assign hit_any  = hit_ien | hit_scol | hit_madr;
	assign kind     = alias_e'(adr_i[3:2]);
	// Single-lane and three-lane patterns count as byte-wide.
	assign byte_acc = !(sel_i == 4'hF || sel_i == 4'h3 || sel_i == 4'hC);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign lanes[g*8 +: 8] = {8{sel_i[g]}};
		end
	endgenerate

	assign wr_ien  = req & we_i & hit_ien;
	assign wr_scol = req & we_i & hit_scol;
	assign wr_madr = req & we_i & hit_madr & ~byte_acc;
	// Plain-register reads clear the tally only if lane 0 or 1 is on.
	assign rd_clr  = req & ~we_i & hit_scol & (kind == ACC_WRITE)
		& (sel_i[0] | sel_i[1]);

	// Hardware count: a frame that ends in the cycle of a clearing read is
	// kept as the first count after the clear; a frame in the cycle of a bus write to the counter is dropped.
	always_comb begin
		scol_hw   = rd_clr | single_coll_frame_i;
		if (rd_clr) begin
			scol_next = single_coll_frame_i ? 32'h0000_0001
				: `SCOL_RESET;
		end else begin
			scol_next = scol + 32'h0000_0001;
		end
	end

	eth_alias_reg #(
		.MASK  (`IEN_MASK),
		.RESET (`IEN_RESET)
	) u_ien (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_i      (wr_ien),
		.kind_i    (kind),
		.data_i    (dat_i),
		.lane_i    (lanes),
		.hw_wr_i   (1'b0),
		.hw_data_i (32'h0000_0000),
		.value_o   (ien)
	);

	eth_alias_reg #(
		.MASK  (`SCOL_MASK),
		.RESET (`SCOL_RESET)
	) u_scol (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_i      (wr_scol),
		.kind_i    (kind),
		.data_i    (dat_i),
		.lane_i    (lanes),
		.hw_wr_i   (scol_hw),
		.hw_data_i (scol_next),
		.value_o   (scol)
	);

	eth_alias_reg #(
		.MASK  (`MADR_MASK),
		.RESET (`MADR_RESET)
	) u_madr (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_i      (wr_madr),
		.kind_i    (kind),
		.data_i    (dat_i),
		.lane_i    (lanes),
		.hw_wr_i   (1'b0),
		.hw_data_i (32'h0000_0000),
		.value_o   (madr)
	);

	// Each enable is taken from its own bit of the enable register.
	assign tx_sysbus_err_int_en    = ien[`IEN_TX_SYSBUS_ERR];
	assign rx_sysbus_err_int_en    = ien[`IEN_RX_SYSBUS_ERR];
	assign empty_watermark_int_en  = ien[`IEN_EMPTY_WMARK];
	assign full_watermark_int_en   = ien[`IEN_FULL_WMARK];
	assign rx_complete_int_en      = ien[`IEN_RX_COMPLETE];
	assign packet_waiting_int_en   = ien[`IEN_PKT_WAITING];
	assign rx_activity_int_en      = ien[`IEN_RX_ACTIVITY];
	assign tx_complete_int_en      = ien[`IEN_TX_COMPLETE];
	assign tx_aborted_int_en       = ien[`IEN_TX_ABORTED];
	assign rx_no_descriptor_int_en = ien[`IEN_RX_NO_DESC];
	assign rx_fifo_overrun_int_en  = ien[`IEN_RX_OVERRUN];
	assign en_vec = {tx_sysbus_err_int_en, rx_sysbus_err_int_en,
		empty_watermark_int_en, full_watermark_int_en, rx_complete_int_en,
		packet_waiting_int_en, rx_activity_int_en, tx_complete_int_en,
		tx_aborted_int_en, rx_no_descriptor_int_en, rx_fifo_overrun_int_en};

	// Each event is gated by its own enable bit.
	generate
		for (g = 0; g < NEV; g++) begin : g_gate
			assign gated[g] = event_flags_i[g] & en_vec[g];
		end
	endgenerate

	always_comb begin
		rdata = 32'h0000_0000;
		if (hit_ien) begin
			rdata = ien & `IEN_MASK;
		end else if (hit_scol) begin
			rdata = scol & `SCOL_MASK;
		end else if (hit_madr) begin
			rdata = madr & `MADR_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & hit_any;
			err_q <= req & ~hit_any;
			dat_q <= (req & ~we_i & hit_any) ? rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |gated;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			madr_q <= '{phy_sel: 5'h01, reg_sel: 5'h00};
		end else begin
			madr_q.phy_sel <= madr[`MADR_PHY_LSB +: 5];
			madr_q.reg_sel <= madr[`MADR_REG_LSB +: 5];
		end
	end

	assign ack_o       = ack_q;
	assign err_o       = err_q;
	assign dat_o       = dat_q;
	assign irq_o       = irq_q;
	assign mgmt_addr_o = madr_q;

	// Checks.
	a_irq_follows: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(|gated) |=> irq_o)
		else $error("irq not raised for enabled event");
	a_irq_blocked: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(|(event_flags_i)) |=> !irq_o)
		else $error("irq raised with no event");
	a_txbus_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(event_flags_i[10] && ien[`IEN_TX_SYSBUS_ERR]) |=> irq_o)
		else $error("tx bus error not gated by bit 14");
	a_rxbus_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h200 |=> irq_o == $past(ien[`IEN_RX_SYSBUS_ERR]))
		else $error("rx bus error gate wrong");
	a_empty_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h100 |=> irq_o == $past(ien[`IEN_EMPTY_WMARK]))
		else $error("empty watermark gate wrong");
	a_full_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h080 |=> irq_o == $past(ien[`IEN_FULL_WMARK]))
		else $error("full watermark gate wrong");
	a_rxdone_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h040 |=> irq_o == $past(ien[`IEN_RX_COMPLETE]))
		else $error("rx complete gate wrong");
	a_pend_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h020 |=> irq_o == $past(ien[`IEN_PKT_WAITING]))
		else $error("packet waiting gate wrong");
	a_rxact_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h010 |=> irq_o == $past(ien[`IEN_RX_ACTIVITY]))
		else $error("rx activity gate wrong");
	a_txdone_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h008 |=> irq_o == $past(ien[`IEN_TX_COMPLETE]))
		else $error("tx complete gate wrong");
	a_abort_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h004 |=> irq_o == $past(ien[`IEN_TX_ABORTED]))
		else $error("tx aborted gate wrong");
	a_nodesc_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_flags_i == 11'h002 |=> irq_o == $past(ien[`IEN_RX_NO_DESC]))
		else $error("no descriptor gate wrong");
	a_ovfl_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(event_flags_i == 11'h001 && !ien[`IEN_RX_OVERRUN]) |=> !irq_o)
		else $error("overrun passed with enable off");
	a_ien_unused: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ien & ~`IEN_MASK) == 32'h0000_0000)
		else $error("unused enable bit set");
	a_ien_rdzero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && hit_ien) |=> (dat_o & ~`IEN_MASK) == 32'h0000_0000)
		else $error("unused enable bit read as one");

	// Single-collision counter.
	a_scol_rdzero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && hit_scol) |=> (dat_o & ~`SCOL_MASK) == 32'h0000_0000)
		else $error("counter upper bits read as one");
	a_scol_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(rd_clr && !single_coll_frame_i) |=> scol == 32'h0000_0000)
		else $error("counter not cleared after read");
	a_clear_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(rd_clr && single_coll_frame_i) |=> scol == 32'h0000_0001)
		else $error("frame lost in clearing read");
	a_scol_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(single_coll_frame_i && !rd_clr && !wr_scol && scol != 32'h0000_FFFF)
		|=> scol == $past(scol) + 32'h0000_0001)
		else $error("counter missed increment");
	a_scol_wrap: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(single_coll_frame_i && !rd_clr && !wr_scol && scol == 32'h0000_FFFF)
		|=> scol == 32'h0000_0000)
		else $error("counter did not wrap at 16 bits");
	a_scol_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!single_coll_frame_i && !rd_clr && !wr_scol) |=> $stable(scol))
		else $error("counter moved with no cause");

	// Management address and bus.
	a_madr_byte: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && we_i && hit_madr && byte_acc) |=> $stable(madr))
		else $error("byte write changed mgmt address");
	a_madr_drive: assert property (
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> mgmt_addr_o.phy_sel == $past(madr[12:8]))
		else $error("phy select not driven");
	a_reg_drive: assert property (
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> mgmt_addr_o.reg_sel == $past(madr[4:0]))
		else $error("register select not driven");
	a_madr_rdzero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && hit_madr) |=> (dat_o & ~`MADR_MASK) == 32'h0000_0000)
		else $error("unused address bit read as one");
	a_ack_once: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held two cycles");

endmodule : eth_irq_stats_mgmt

// ===== inc/eth_slice_regs.svh
// Register offsets, field positions, reset values for the Ethernet slice.
// Assumes byte addressing on a 32-bit Wishbone bus, one word per register.
`ifndef ETH_SLICE_REGS_SVH
`define ETH_SLICE_REGS_SVH

`define IEN_BASE        8'h00
`define SCOL_BASE       8'h10
`define MADR_BASE       8'h20
`define ALIAS_CLR       2'h1
`define ALIAS_SET       2'h2
`define ALIAS_INV       2'h3
`define IEN_MASK        32'h0000_63EF
`define SCOL_MASK       32'h0000_FFFF
`define MADR_MASK       32'h0000_1F1F
`define IEN_RESET       32'h0000_0000
`define SCOL_RESET      32'h0000_0000
`define MADR_RESET      32'h0000_0100
`define MADR_PHY_LSB    8
`define MADR_REG_LSB    0
`define IEN_TX_SYSBUS_ERR 14
`define IEN_RX_SYSBUS_ERR 13
`define IEN_EMPTY_WMARK   9
`define IEN_FULL_WMARK    8
`define IEN_RX_COMPLETE   7
`define IEN_PKT_WAITING   6
`define IEN_RX_ACTIVITY   5
`define IEN_TX_COMPLETE   3
`define IEN_TX_ABORTED    2
`define IEN_RX_NO_DESC    1
`define IEN_RX_OVERRUN    0
`define NUM_EVENTS      11

`endif

// ===== inc/eth_slice_pkg.sv
// Types shared by the Ethernet register slice.
// Assumes the offsets and masks of eth_slice_regs.svh.
package eth_slice_pkg;

	typedef struct packed {
		logic [4:0] phy_sel;
		logic [4:0] reg_sel;
	} mgmt_addr_s;

	typedef enum logic [1:0] {
		ACC_WRITE,
		ACC_CLR,
		ACC_SET,
		ACC_INV
	} alias_e;

endpackage : eth_slice_pkg

// ===== verilog/eth_alias_reg.sv
// One 32-bit register with write, clear, set and invert aliases.
// Assumes the caller decodes the alias and qualifies the write strobe.
`timescale 1ns/1ps
module eth_alias_reg #(
	parameter logic [31:0] MASK  = 32'hFFFF_FFFF,
	parameter logic [31:0] RESET = 32'h0000_0000
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Write request
	input  wire logic                     wr_i,
	input  wire eth_slice_pkg::alias_e    kind_i,
	input  wire logic [31:0]              data_i,
	input  wire logic [31:0]              lane_i,
	// Hardware update, taken when no write is active
	input  wire logic                     hw_wr_i,
	input  wire logic [31:0]              hw_data_i,
	// Stored value
	output logic      [31:0]              value_o
);
	import eth_slice_pkg::*;

	logic [31:0] value_q;
	logic [31:0] value_d;
	logic [31:0] bits;

	// On a bus write only bits inside the enabled byte lanes change.
	always_comb begin
		bits = data_i & lane_i;
		value_d = value_q;
		if (wr_i) begin
			unique case (kind_i)
				ACC_WRITE: value_d = (value_q & ~lane_i) | bits;
				ACC_CLR:   value_d = value_q & ~bits;
				ACC_SET:   value_d = value_q | bits;
				ACC_INV:   value_d = value_q ^ bits;
			endcase
		end else if (hw_wr_i) begin
			value_d = hw_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			value_q <= RESET;
		end else begin
			value_q <= value_d & MASK;
		end
	end

	assign value_o = value_q;

endmodule : eth_alias_reg

// ===== tb/eth_event_src.sv
// Event source standing in for the controller's transmit and receive logic.
// Assumes bench commands arrive on the same clock as the register slice.
`timescale 1ns/1ps
module eth_event_src (
	// Clock
	input  wire logic        clk_i,
	// Bench commands
	input  wire logic [10:0] flags_cmd_i,
	input  wire logic        coll_cmd_i,
	// Event levels and second-attempt pulses
	output logic      [10:0] event_flags_o,
	output logic             coll_pulse_o
);
	// Registered so every level changes just after an edge, never on it.
	always @(posedge clk_i) begin
		event_flags_o <= flags_cmd_i;
		coll_pulse_o  <= coll_cmd_i;
	end
endmodule : eth_event_src

// ===== tb/eth_irq_stats_mgmt_tb_top.sv
// Self-checking bench for the Ethernet enable, counter and address slice.
// Assumes a classic Wishbone slave answering one cycle after the take.
`timescale 1ns/1ps
module eth_irq_stats_mgmt_tb_top;
	import eth_slice_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, coll_cmd, coll_p, berr;
	logic        ack_o, err_o, irq_o;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_o, rd;
	logic [10:0] flags_cmd, flags;
	mgmt_addr_s  mgmt_addr_o;
	int          mismatches = 0;
	int          checks_done = 0;
	int          bitpos[11] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 13, 14};

	eth_irq_stats_mgmt eth_irq_stats_mgmt_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
		.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.event_flags_i(flags), .single_coll_frame_i(coll_p),
		.irq_o(irq_o), .mgmt_addr_o(mgmt_addr_o));
	eth_event_src eth_event_src_inst (
		.clk_i(clk_i), .flags_cmd_i(flags_cmd), .coll_cmd_i(coll_cmd),
		.event_flags_o(flags), .coll_pulse_o(coll_p));

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; a wait that never sees an answer ends the run.
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_w <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			$display("BAD %0t no answer on the bus", $time);
			mismatches++;
			summarize();
		end
		rd = dat_o;
		berr = err_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd_chk(input logic [7:0] a, input logic [3:0] s,
			input logic [31:0] exp);
		wb(1'b0, a, s, 32'h0);
		chk(rd, exp);
	endtask : rd_chk

	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			coll_cmd <= 1'b1;
			@(posedge clk_i);
			coll_cmd <= 1'b0;
			@(posedge clk_i);
		end
		@(posedge clk_i);
	endtask : pulses

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, coll_cmd, adr, sel, dat_w, flags_cmd} = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({22'h0, mgmt_addr_o}, 32'h20);
		rd_chk(8'h00, 4'hF, 32'h0);
		rd_chk(8'h10, 4'hF, 32'h0);
		rd_chk(8'h20, 4'hF, 32'h100);
		$display("test reset done");
		wb(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF);
		rd_chk(8'h00, 4'hF, 32'h63EF);
		wb(1'b1, 8'h04, 4'hF, 32'h0000_000F);
		rd_chk(8'h00, 4'hF, 32'h63E0);
		wb(1'b1, 8'h0C, 4'hF, 32'h0000_0003);
		wb(1'b1, 8'h08, 4'hF, 32'h0000_0010);
		rd_chk(8'h00, 4'hF, 32'h63E3);
		// Only the enable matching the one raised event may pass it.
		for (int i = 0; i < 11; i++) begin
			wb(1'b1, 8'h00, 4'hF, 32'h1 << bitpos[i]);
			flags_cmd <= ~(11'h1 << i);
			repeat (3) @(posedge clk_i);
			chk({31'h0, irq_o}, 32'h0);
			flags_cmd <= 11'h1 << i;
			repeat (3) @(posedge clk_i);
			chk({31'h0, irq_o}, 32'h1);
		end
		flags_cmd <= 11'h0;
		$display("test enables done");
		pulses(3);
		rd_chk(8'h10, 4'hF, 32'h3);
		rd_chk(8'h10, 4'hF, 32'h0);
		pulses(2);
		rd_chk(8'h10, 4'hC, 32'h2);
		rd_chk(8'h10, 4'h2, 32'h2);
		rd_chk(8'h10, 4'hF, 32'h0);
		wb(1'b1, 8'h18, 4'hF, 32'h5);
		rd_chk(8'h10, 4'hF, 32'h5);
		// A frame finished in the read's own cycle survives the clear.
		coll_cmd <= 1'b1;
		@(posedge clk_i);
		coll_cmd <= 1'b0;
		rd_chk(8'h10, 4'hF, 32'h0);
		rd_chk(8'h10, 4'hF, 32'h1);
		$display("test counter done");
		wb(1'b1, 8'h20, 4'hF, 32'h1A05);
		rd_chk(8'h20, 4'hF, 32'h1A05);
		chk({22'h0, mgmt_addr_o}, {22'h0, 5'h1A, 5'h05});
		wb(1'b1, 8'h20, 4'h1, 32'h0);
		wb(1'b1, 8'h28, 4'h2, 32'hFFFF);
		rd_chk(8'h20, 4'hF, 32'h1A05);
		wb(1'b1, 8'h20, 4'h3, 32'h0203);
		rd_chk(8'h20, 4'hF, 32'h0203);
		wb(1'b1, 8'h2C, 4'hF, 32'h1F00);
		rd_chk(8'h20, 4'hF, 32'h1D03);
		wb(1'b0, 8'h30, 4'hF, 32'h0);
		chk({31'h0, berr}, 32'h1);
		$display("test address done");
		summarize();
	end
endmodule : eth_irq_stats_mgmt_tb_top
